// [verilog/lpc_params.svh]
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH

// register byte addresses
`define LPC_ADDR_TRIM     32'hFFFF042C
`define LPC_ADDR_CTRL     32'hFFFF0440
`define LPC_ADDR_STATUS   32'hFFFF0444
`define LPC_ADDR_REF_CNT  32'hFFFF0448
`define LPC_ADDR_MEAS_CNT 32'hFFFF044C

// reset values
`define LPC_TRIM_RESET    4'h8
`define LPC_CTRL_RESET    8'h00
`define LPC_STATUS_RESET  8'h00

// control fields
`define LPC_CTRL_SRC      4
`define LPC_CTRL_CAL_RST  3
`define LPC_CTRL_CLR_MEAS 2
`define LPC_CTRL_CLR_REF  1
`define LPC_CTRL_EN       0

// status fields
`define LPC_STA_DONE      1
`define LPC_STA_BUSY      0

// counter limits
`define LPC_REF_FULL      9'h1FF
`define LPC_MEAS_FULL     10'h3FF
`define LPC_DIV_LAST      2'h3

// bus responses
`define LPC_RESP_OKAY     2'h0
`define LPC_RESP_SLVERR   2'h2

`endif

// [verilog/lpc_pkg.sv]
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_IDLE = 2'b00,
    LPC_RUN  = 2'b01,
    LPC_DONE = 2'b10
  } lpc_state_t;
  typedef logic [31:0] lpc_word_t;
endpackage

// [verilog/lpc_reg_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface lpc_reg_if;
  logic                wr_stb;
  logic                rd_stb;
  lpc_pkg::lpc_word_t  wr_addr;
  lpc_pkg::lpc_word_t  rd_addr;
  lpc_pkg::lpc_word_t  wdata;
  logic [3:0]          wstrb;
  lpc_pkg::lpc_word_t  rdata;
  logic                wr_hit;
  logic                rd_hit;
  modport bus  (output wr_stb, rd_stb, wr_addr, rd_addr, wdata, wstrb, input rdata, wr_hit, rd_hit);
  modport regs (input wr_stb, rd_stb, wr_addr, rd_addr, wdata, wstrb, output rdata, wr_hit, rd_hit);
endinterface
`default_nettype wire

// [verilog/lpc_axil_slave.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"
module lpc_axil_slave (
  // clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset,
  // write channels
  input  wire logic   s_axi_awvalid,
  output logic        s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic   s_axi_wvalid,
  output logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic        s_axi_bvalid,
  input  wire logic   s_axi_bready,
  output logic [1:0]  s_axi_bresp,
  // read channels
  input  wire logic   s_axi_arvalid,
  output logic        s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic        s_axi_rvalid,
  input  wire logic   s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  // register side
  lpc_reg_if.bus      rif
);
  import lpc_pkg::*;

  logic        aw_held, next_aw_held, w_held, next_w_held;
  lpc_word_t   aw_addr, next_aw_addr, w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  lpc_word_t   next_rdata;

  // write fires once both halves are held and the response slot is free
  assign rif.wr_stb  = aw_held && w_held && !s_axi_bvalid;
  assign rif.wr_addr = aw_addr;
  assign rif.wdata   = w_data;
  assign rif.wstrb   = w_strb;
  assign rif.rd_stb  = s_axi_arvalid && s_axi_arready;
  assign rif.rd_addr = s_axi_araddr;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (rif.wr_stb) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = rif.wr_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (rif.rd_stb) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = rif.rdata;
      next_rresp   = rif.rd_hit ? `LPC_RESP_OKAY : `LPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_arready = 1'b1;
      next_rvalid  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_held       <= 1'b0;
      aw_addr       <= 32'h00000000;
      w_held        <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LPC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LPC_RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      // ready mirrors the next hold state so the pin leaves a flop
      s_axi_awready <= !next_aw_held;
      s_axi_wready  <= !next_w_held;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end
endmodule
`default_nettype wire

// [verilog/lpc_edge_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module lpc_edge_counter #(
  parameter int                W    = 9,
  parameter logic [W-1:0]      LAST = '1
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // control
  input  wire logic         clear,
  input  wire logic         tick,
  // value
  output logic [W-1:0]      count
);
  import lpc_pkg::*;

  logic [W-1:0] next_count;

  // saturates rather than wraps, so a runaway source never reads as small
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (tick && count != LAST) begin
      next_count = count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// [verilog/lpc_osc_cal.sv]
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"
// Functional notes
// R1: 9-bit reference counter counts precision oscillator or crystal, per selected source.
// R2: 10-bit measured counter counts low-power oscillator, direct or divided by four.
// R3: software pairs equal frequencies on both counters.
// R4: trim register 8 bits; bits 3..0 trim, bits 7..4 reserved, zero.
// R5: larger trim value slows the low-power oscillator; range about 127-135 kHz.
// R6: both counters stop when reference count reaches 0x1FF.
// R7: software compares counts and moves trim toward equality.
// R8: software reruns calibration after every trim change.
// R9: software moves the PLL onto a stable source before calibrating.
// R10: control bit 4 selects crystal when 1, precision oscillator when 0.
// R11: control bit 3 clears both counters and disables calibration.
// R12: control bit 2 clears measured counter, bit 1 clears reference counter.
// R13: control bit 0 starts calibration; clearing it aborts a running cycle.
// R14: status bit 1 set on completion, cleared by reading measured count.
// R15: status bit 0 reads 1 while calibration runs.
// R16: a cycle takes about 4 ms precision, 16 ms crystal reference.
// R17: crystal source routes low-power clock through divide-by-4; else direct.
module lpc_osc_cal (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // oscillator levels, sampled on clk_sys
  input  wire logic        prec_osc_in,
  input  wire logic        xtal_osc_in,
  input  wire logic        lp_osc_in,
  // oscillator control
  output logic [3:0]       trim_code,
  output logic             cal_busy,
  // axi4-lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);
  import lpc_pkg::*;

  lpc_reg_if  rif ();

  lpc_state_t state;
  lpc_state_t next_state;
  logic [2:0] osc_prev;
  logic [2:0] next_osc_prev;
  logic [2:0] osc_edge;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic       src_xtal;
  logic       next_src_xtal;
  logic       en_bit;
  logic       next_en_bit;
  logic       done_flag;
  logic       next_done_flag;
  logic [3:0] next_trim_code;
  logic       next_cal_busy;
  logic [8:0] ref_count;
  logic [9:0] meas_count;
  logic       ctrl_wr;
  logic       trim_wr;
  logic       meas_rd;
  logic [7:0] wd;
  logic       ref_tick;
  logic       meas_tick;
  logic       ref_clr;
  logic       meas_clr;
  logic       counting;
  logic       finish;

  lpc_axil_slave u_slave (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .rif           (rif)
  );

  // all writable fields live in byte lane 0
  assign wd      = rif.wdata[7:0];
  assign ctrl_wr = rif.wr_stb && rif.wr_addr == `LPC_ADDR_CTRL && rif.wstrb[0];
  assign trim_wr = rif.wr_stb && rif.wr_addr == `LPC_ADDR_TRIM && rif.wstrb[0];
  assign meas_rd = rif.rd_stb && rif.rd_addr == `LPC_ADDR_MEAS_CNT;
  assign rif.wr_hit = rif.wr_addr inside {`LPC_ADDR_TRIM,
                                          `LPC_ADDR_CTRL,
                                          `LPC_ADDR_STATUS,
                                          `LPC_ADDR_REF_CNT,
                                          `LPC_ADDR_MEAS_CNT};
  assign rif.rd_hit = rif.rd_addr inside {`LPC_ADDR_TRIM,
                                          `LPC_ADDR_CTRL,
                                          `LPC_ADDR_STATUS,
                                          `LPC_ADDR_REF_CNT,
                                          `LPC_ADDR_MEAS_CNT};

  // action bits 3..1 self-clear and read back as zero
  always_comb begin
    case (rif.rd_addr)
      `LPC_ADDR_TRIM:     rif.rdata = {28'h0000000, trim_code}; // R4
      `LPC_ADDR_CTRL:     rif.rdata = {27'h0000000, src_xtal, 3'h0, en_bit};
      `LPC_ADDR_STATUS:   rif.rdata = {30'h00000000, done_flag, cal_busy}; // R15
      `LPC_ADDR_REF_CNT:  rif.rdata = {23'h000000, ref_count};
      `LPC_ADDR_MEAS_CNT: rif.rdata = {22'h000000, meas_count};
      default:            rif.rdata = 32'h00000000;
    endcase
  end

  // inputs are synchronous, so one sample suffices for edge detection
  // a pin high out of reset gives one false edge, harmless while idle
  assign next_osc_prev = {lp_osc_in, xtal_osc_in, prec_osc_in};
  assign osc_edge      = next_osc_prev & ~osc_prev;

  // reference at 131 kHz ends after ~4 ms, at 32.768 kHz after ~16 ms
  assign ref_tick  = src_xtal ? osc_edge[1] : osc_edge[0]; // R1 R10 R16
  assign meas_tick = src_xtal ? (osc_edge[2] && div_cnt == `LPC_DIV_LAST) : osc_edge[2]; // R2 R17
  assign counting  = state == LPC_RUN && ref_count != `LPC_REF_FULL; // R6
  assign finish    = state == LPC_RUN && ref_count == `LPC_REF_FULL; // R6
  assign ref_clr   = ctrl_wr && (wd[`LPC_CTRL_CAL_RST] || wd[`LPC_CTRL_CLR_REF]); // R11 R12
  assign meas_clr  = ctrl_wr && (wd[`LPC_CTRL_CAL_RST] || wd[`LPC_CTRL_CLR_MEAS]); // R11 R12

  // a start keeps old counts; software clears them in the same write
  lpc_edge_counter #(.W(9), .LAST(`LPC_REF_FULL)) u_ref_cnt (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clear   (ref_clr),
    .tick    (ref_tick && counting),
    .count   (ref_count)
  );

  lpc_edge_counter #(.W(10), .LAST(`LPC_MEAS_FULL)) u_meas_cnt (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clear   (meas_clr),
    .tick    (meas_tick && counting),
    .count   (meas_count)
  );

  always_comb begin
    next_state     = state;
    next_en_bit    = en_bit;
    next_src_xtal  = src_xtal;
    next_div_cnt   = div_cnt;
    next_done_flag = done_flag;
    next_trim_code = trim_code;
    if (trim_wr) begin
      // higher code slows the oscillator; reserved bits are dropped
      next_trim_code = wd[3:0]; // R4 R5
    end
    if (counting && osc_edge[2]) begin
      next_div_cnt = div_cnt + 2'h1; // R17
    end
    if (ctrl_wr) begin
      next_src_xtal = wd[`LPC_CTRL_SRC]; // R10
      next_en_bit   = wd[`LPC_CTRL_EN] && !wd[`LPC_CTRL_CAL_RST];
      if (wd[`LPC_CTRL_CAL_RST] || !wd[`LPC_CTRL_EN]) begin
        next_state = LPC_IDLE; // R11 R13
      end else if (state != LPC_RUN) begin
        next_state   = LPC_RUN; // R13
        next_div_cnt = 2'h0;
      end
    end else if (finish) begin
      next_state = LPC_DONE; // R6
    end
    // completion wins over a simultaneous read clear
    if (meas_rd) begin
      next_done_flag = 1'b0; // R14
    end
    if (finish && !ctrl_wr) begin
      next_done_flag = 1'b1; // R14
    end
  end

  assign next_cal_busy = next_state == LPC_RUN; // R15

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state     <= LPC_IDLE;
      osc_prev  <= 3'h0;
      div_cnt   <= 2'h0;
      src_xtal  <= 1'b0;
      en_bit    <= 1'b0;
      done_flag <= 1'b0;
      trim_code <= `LPC_TRIM_RESET;
      cal_busy  <= 1'b0;
    end else begin
      state     <= next_state;
      osc_prev  <= next_osc_prev;
      div_cnt   <= next_div_cnt;
      src_xtal  <= next_src_xtal;
      en_bit    <= next_en_bit;
      done_flag <= next_done_flag;
      trim_code <= next_trim_code;
      cal_busy  <= next_cal_busy;
    end
  end

  chk_stop_at_full: assert property (@(posedge clk_sys) disable iff (reset) // R6
    finish && !ctrl_wr |=> state == LPC_DONE && done_flag && !cal_busy)
    else $error("calibration did not stop at full reference count");

  chk_counts_frozen: assert property (@(posedge clk_sys) disable iff (reset) // R6
    state != LPC_RUN && !ref_clr && !meas_clr |=> $stable(ref_count) && $stable(meas_count))
    else $error("counter moved while calibration was not running");

  chk_ref_step: assert property (@(posedge clk_sys) disable iff (reset) // R1
    counting && ref_tick && !ref_clr |=> ref_count == $past(ref_count) + 9'h001)
    else $error("reference counter missed a source edge");

  chk_div_ratio: assert property (@(posedge clk_sys) disable iff (reset) // R17
    counting && src_xtal && !meas_clr && !(osc_edge[2] && div_cnt == `LPC_DIV_LAST)
    |=> $stable(meas_count))
    else $error("measured counter stepped off the divide-by-four edge");

  chk_cal_reset: assert property (@(posedge clk_sys) disable iff (reset) // R11
    ctrl_wr && wd[`LPC_CTRL_CAL_RST] |=> ref_count == 9'h000 && meas_count == 10'h000
    && state == LPC_IDLE && !en_bit)
    else $error("calibration reset left counters or logic active");

  chk_meas_clear: assert property (@(posedge clk_sys) disable iff (reset) // R12
    ctrl_wr && wd[`LPC_CTRL_CLR_MEAS] |=> meas_count == 10'h000)
    else $error("measured counter not cleared");

  chk_ref_clear: assert property (@(posedge clk_sys) disable iff (reset) // R12
    ctrl_wr && wd[`LPC_CTRL_CLR_REF] |=> ref_count == 9'h000)
    else $error("reference counter not cleared");

  chk_start_abort: assert property (@(posedge clk_sys) disable iff (reset) // R13
    ctrl_wr && !wd[`LPC_CTRL_CAL_RST] |=> cal_busy == $past(wd[`LPC_CTRL_EN]))
    else $error("enable write did not start or abort calibration");

  chk_done_clear: assert property (@(posedge clk_sys) disable iff (reset) // R14
    meas_rd && !finish |=> !done_flag)
    else $error("reading measured count did not clear completion");

  chk_busy_state: assert property (@(posedge clk_sys) disable iff (reset) // R15
    cal_busy == (state == LPC_RUN) && (!cal_busy || en_bit))
    else $error("busy status disagrees with calibration state");

  chk_trim_width: assert property (@(posedge clk_sys) disable iff (reset) // R4
    trim_wr |=> trim_code == $past(wd[3:0]))
    else $error("trim write not taken in low four bits");

  chk_ref_hold_full: assert property (@(posedge clk_sys) disable iff (reset) // R6
    ref_count == `LPC_REF_FULL && !ref_clr |=> ref_count == `LPC_REF_FULL)
    else $error("reference counter left full count without a clear");

  chk_src_select: assert property (@(posedge clk_sys) disable iff (reset) // R10
    counting && !ref_clr && !(src_xtal ? osc_edge[1] : osc_edge[0]) |=> $stable(ref_count))
    else $error("reference counter stepped on the unselected source");

  chk_meas_step: assert property (@(posedge clk_sys) disable iff (reset) // R2
    counting && meas_tick && !meas_clr && meas_count != `LPC_MEAS_FULL
    |=> meas_count == $past(meas_count) + 10'h001)
    else $error("measured counter missed a low-power tick");

  chk_direct_meas: assert property (@(posedge clk_sys) disable iff (reset) // R17
    counting && !src_xtal && osc_edge[2] && !meas_clr && meas_count != `LPC_MEAS_FULL
    |=> meas_count == $past(meas_count) + 10'h001)
    else $error("direct low-power edge not counted");

  chk_div_reset: assert property (@(posedge clk_sys) disable iff (reset) // R17
    ctrl_wr && wd[`LPC_CTRL_EN] && !wd[`LPC_CTRL_CAL_RST] && state != LPC_RUN |=> div_cnt == 2'h0)
    else $error("divider not restarted with calibration");

  chk_abort_idle: assert property (@(posedge clk_sys) disable iff (reset) // R13
    ctrl_wr && !wd[`LPC_CTRL_EN] |=> state == LPC_IDLE && !cal_busy)
    else $error("clearing enable did not abort calibration");

  chk_done_rise: assert property (@(posedge clk_sys) disable iff (reset) // R14
    $rose(done_flag) |-> $past(finish))
    else $error("completion flag set without a finished cycle");

  chk_trim_hold: assert property (@(posedge clk_sys) disable iff (reset) // R4
    !trim_wr |=> $stable(trim_code))
    else $error("trim changed without a trim write");
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lpc_params.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
  import lpc_pkg::*;
  logic        clk_sys;
  logic        reset;
  logic        prec_osc_in;
  logic        xtal_osc_in;
  logic        lp_osc_in;
  logic [3:0]  trim_code;
  logic        cal_busy;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  lpc_word_t   s_axi_awaddr;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  lpc_word_t   s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  lpc_word_t   s_axi_araddr;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  lpc_word_t   s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic [2:0]  phase;
  logic        lp_fast;
  logic [1:0]  rd_resp;
  int          miscompares;
  int          compares;

  lpc_osc_cal lpc_osc_cal_inst (
    .clk_sys(clk_sys), .reset(reset), .prec_osc_in(prec_osc_in), .xtal_osc_in(xtal_osc_in),
    .lp_osc_in(lp_osc_in), .trim_code(trim_code), .cal_busy(cal_busy),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
  );

  always #50 clk_sys = ~clk_sys;

  // with lp_fast low, precision and low-power share one waveform so equal counts are exact
  always @(posedge clk_sys) begin
    phase <= phase + 3'h1;
    // references are never retrimmed, so a clock fed from them stays locked
    prec_osc_in <= phase[1];
    xtal_osc_in <= phase[2];
    lp_osc_in <= lp_fast ? phase[0] : phase[1];
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input lpc_word_t a, input lpc_word_t d, input logic [1:0] er);
    bit got;
    got = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!got) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        got = 1;
        `CHK("write resp", er, s_axi_bresp)
      end
    end
  endtask

  task automatic rd(input lpc_word_t a, output lpc_word_t d);
    bit got;
    got = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1;
        d = s_axi_rdata;
        rd_resp = s_axi_rresp;
      end
    end
  endtask

  task automatic chk_rd(input string nm, input lpc_word_t a, input lpc_word_t e, input logic [1:0] er);
    lpc_word_t d;
    rd(a, d);
    `CHK(nm, e, d)
    `CHK("read resp", er, rd_resp)
  endtask

  // two edges first so the start edge has landed before busy is sampled
  task automatic wait_idle(output int n);
    n = 0;
    repeat (2) @(posedge clk_sys);
    while (cal_busy !== 1'b0 && n < 10000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("idle wait", 1'b1, n < 10000)
  endtask

  task automatic test_reset();
    chk_rd("trim", `LPC_ADDR_TRIM, 32'h8, `LPC_RESP_OKAY);
    chk_rd("control", `LPC_ADDR_CTRL, 32'h0, `LPC_RESP_OKAY);
    chk_rd("status", `LPC_ADDR_STATUS, 32'h0, `LPC_RESP_OKAY);
    chk_rd("ref count", `LPC_ADDR_REF_CNT, 32'h0, `LPC_RESP_OKAY);
    chk_rd("meas count", `LPC_ADDR_MEAS_CNT, 32'h0, `LPC_RESP_OKAY);
    `CHK("trim_code", 4'h8, trim_code)
    `CHK("cal_busy", 1'b0, cal_busy)
  endtask

  task automatic test_regs();
    wr(`LPC_ADDR_TRIM, 32'hFFFFFFFF, `LPC_RESP_OKAY);
    chk_rd("trim", `LPC_ADDR_TRIM, 32'hF, `LPC_RESP_OKAY);
    `CHK("trim_code", 4'hF, trim_code)
    wr(`LPC_ADDR_TRIM, 32'h3, `LPC_RESP_OKAY);
    `CHK("trim_code", 4'h3, trim_code)
    s_axi_wstrb <= 4'hE;
    wr(`LPC_ADDR_TRIM, 32'h5, `LPC_RESP_OKAY);
    `CHK("masked trim", 4'h3, trim_code)
    s_axi_wstrb <= 4'hF;
    wr(`LPC_ADDR_STATUS, 32'hFF, `LPC_RESP_OKAY);
    chk_rd("status", `LPC_ADDR_STATUS, 32'h0, `LPC_RESP_OKAY);
    wr(32'hFFFF0450, 32'h1, `LPC_RESP_SLVERR);
    chk_rd("unmapped", 32'hFFFF0450, 32'h0, `LPC_RESP_SLVERR);
  endtask

  task automatic test_precision();
    int n;
    lp_fast <= 1'b0;
    wr(`LPC_ADDR_CTRL, 32'h07, `LPC_RESP_OKAY);
    wait_idle(n);
    `CHK("cycle time", 1'b1, n > 511 * 4 - 12 && n < 511 * 4 + 8)
    chk_rd("status", `LPC_ADDR_STATUS, 32'h2, `LPC_RESP_OKAY);
    chk_rd("ref count", `LPC_ADDR_REF_CNT, 32'h1FF, `LPC_RESP_OKAY);
    chk_rd("meas count", `LPC_ADDR_MEAS_CNT, 32'h1FF, `LPC_RESP_OKAY);
    chk_rd("status", `LPC_ADDR_STATUS, 32'h0, `LPC_RESP_OKAY);
    wr(`LPC_ADDR_CTRL, 32'h02, `LPC_RESP_OKAY);
    chk_rd("ref count", `LPC_ADDR_REF_CNT, 32'h0, `LPC_RESP_OKAY);
    chk_rd("meas count", `LPC_ADDR_MEAS_CNT, 32'h1FF, `LPC_RESP_OKAY);
    wr(`LPC_ADDR_CTRL, 32'h04, `LPC_RESP_OKAY);
    chk_rd("meas count", `LPC_ADDR_MEAS_CNT, 32'h0, `LPC_RESP_OKAY);
  endtask

  // lp runs four times the crystal rate: only the divider makes the counts meet
  task automatic test_crystal();
    int n;
    lpc_word_t d;
    lp_fast <= 1'b1;
    wr(`LPC_ADDR_CTRL, 32'h17, `LPC_RESP_OKAY);
    wait_idle(n);
    `CHK("cycle time", 1'b1, n > 511 * 8 - 20 && n < 511 * 8 + 12)
    chk_rd("ref count", `LPC_ADDR_REF_CNT, 32'h1FF, `LPC_RESP_OKAY);
    rd(`LPC_ADDR_MEAS_CNT, d);
    `CHK("meas near ref", 1'b1, d >= 32'h1FE && d <= 32'h200)
    chk_rd("control", `LPC_ADDR_CTRL, 32'h11, `LPC_RESP_OKAY);
  endtask

  task automatic test_abort();
    lp_fast <= 1'b0;
    wr(`LPC_ADDR_CTRL, 32'h07, `LPC_RESP_OKAY);
    repeat (20) @(posedge clk_sys);
    `CHK("cal_busy", 1'b1, cal_busy)
    chk_rd("status", `LPC_ADDR_STATUS, 32'h1, `LPC_RESP_OKAY);
    wr(`LPC_ADDR_CTRL, 32'h00, `LPC_RESP_OKAY);
    chk_rd("status", `LPC_ADDR_STATUS, 32'h0, `LPC_RESP_OKAY);
    `CHK("cal_busy", 1'b0, cal_busy)
    wr(`LPC_ADDR_CTRL, 32'h01, `LPC_RESP_OKAY);
    repeat (20) @(posedge clk_sys);
    wr(`LPC_ADDR_CTRL, 32'h08, `LPC_RESP_OKAY);
    chk_rd("status", `LPC_ADDR_STATUS, 32'h0, `LPC_RESP_OKAY);
    chk_rd("ref count", `LPC_ADDR_REF_CNT, 32'h0, `LPC_RESP_OKAY);
    chk_rd("meas count", `LPC_ADDR_MEAS_CNT, 32'h0, `LPC_RESP_OKAY);
  endtask

  initial begin
    #(20000 * 100);
    miscompares++;
    give_verdict();
  end

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    phase = 3'h0;
    lp_fast = 1'b0;
    prec_osc_in = 1'b0;
    xtal_osc_in = 1'b0;
    lp_osc_in = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_rready = 1'b1;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    test_reset();
    test_regs();
    test_precision();
    test_crystal();
    test_abort();
    give_verdict();
  end
endmodule
`default_nettype wire
